// [core/tru_map.svh]
`ifndef TRU_MAP_SVH
`define TRU_MAP_SVH

// register byte offsets
`define TRU_CTRL_OFS 8'h00
`define TRU_STATUS_OFS 8'h04
`define TRU_TRIP_OFS 8'h08

// control register fields
`define TRU_CTRL_ENABLE_BIT 0
`define TRU_CTRL_LOCKCLR_BIT 1
`define TRU_CTRL_RESET 32'h0000_0000

// status register fields
`define TRU_ST_PON_BIT 0
`define TRU_ST_MAIN_BIT 1
`define TRU_ST_REEL_BIT 2
`define TRU_ST_VAC_BIT 3
`define TRU_ST_REW_BIT 4
`define TRU_ST_LOCK_BIT 5
`define TRU_ST_FWD_BIT 6
`define TRU_ST_BWD_BIT 7
`define TRU_ST_READ_BIT 8
`define TRU_ST_WRITE_BIT 9
`define TRU_ST_DIR_BIT 10
`define TRU_ST_INH_BIT 11
`define TRU_ST_MOT_LSB 12
`define TRU_ST_MOT_MSB 13

// trip register: sticky over-temperature flag, write one to clear
`define TRU_TRIP_OT_BIT 0

// tape path width: seven data channels plus sprocket
`define TRU_CHANNELS 8

`endif

// [core/tru_pkg.sv]
package tru_pkg;

  // coarse motion state of the transport, visible in status
  typedef enum logic [1:0] {
    TRU_MOT_IDLE,
    TRU_MOT_FWD,
    TRU_MOT_BWD,
    TRU_MOT_REWIND
  } tru_motion_e;

  typedef logic [7:0] tru_addr_t;
  typedef logic [31:0] tru_word_t;

endpackage : tru_pkg

// [core/tru_cmd_if.sv]
`timescale 1ns/100ps

// command pins in, relay states out, between top and decoder
interface tru_cmd_if #(parameter int CHANNELS = 8);
  logic enable;
  logic unit_select;
  logic rewind_command;
  logic rewind_interlock_request;
  logic forward_command;
  logic backward_command;
  logic read_command;
  logic write_command;
  logic rewind_done;
  logic lock_clear;
  logic fwd_drive;
  logic bwd_drive;
  logic rewind_relay;
  logic rewind_lockout;
  logic [CHANNELS-1:0] read_path;
  logic [CHANNELS-1:0] write_path;
  tru_pkg::tru_motion_e motion;

  modport ctl (
    output enable, unit_select, rewind_command, rewind_interlock_request, forward_command,
    output backward_command, read_command, write_command, rewind_done, lock_clear,
    input fwd_drive, bwd_drive, rewind_relay, rewind_lockout, read_path, write_path, motion
  );
  modport dec (
    input enable, unit_select, rewind_command, rewind_interlock_request, forward_command,
    input backward_command, read_command, write_command, rewind_done, lock_clear,
    output fwd_drive, bwd_drive, rewind_relay, rewind_lockout, read_path, write_path, motion
  );
endinterface : tru_cmd_if

// [core/tru_cmd_decode.sv]
`timescale 1ns/100ps

module tru_cmd_decode #(
  parameter int CHANNELS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  tru_cmd_if.dec cmd
);

  logic fwd_q;
  logic bwd_q;
  logic rew_q;
  logic lock_q;
  logic rd_q;
  logic wr_q;
  logic [CHANNELS-1:0] rd_path_q;
  logic [CHANNELS-1:0] wr_path_q;
  tru_pkg::tru_motion_e mot_q;
  tru_pkg::tru_motion_e mot_d;

  // a reference counts only when selected, powered, enabled and not locked out
  wire ref_ok = cmd.enable & cmd.unit_select & ~lock_q;
  wire fwd_d = ref_ok & cmd.forward_command & ~cmd.backward_command;
  wire bwd_d = ref_ok & cmd.backward_command & ~cmd.forward_command;
  wire rd_d = ref_ok & cmd.read_command & ~cmd.write_command;
  wire wr_d = ref_ok & cmd.write_command & ~cmd.read_command;
  // rewind latches until the transport reports it finished
  wire rew_d = (rew_q | (ref_ok & cmd.rewind_command)) & ~cmd.rewind_done;
  // lockout set wins over a same-cycle clear
  wire lock_d = (cmd.unit_select & cmd.rewind_interlock_request)
              | (lock_q & ~(cmd.rewind_done | cmd.lock_clear));

  // motion summary; opposing commands together leave the drive idle
  always_comb begin
    case ({rew_d, fwd_d, bwd_d})
      3'b100, 3'b110, 3'b101, 3'b111: mot_d = tru_pkg::TRU_MOT_REWIND;
      3'b010: mot_d = tru_pkg::TRU_MOT_FWD;
      3'b001: mot_d = tru_pkg::TRU_MOT_BWD;
      default: mot_d = tru_pkg::TRU_MOT_IDLE;
    endcase
  end

  // relay coils
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q <= 1'b0;
      bwd_q <= 1'b0;
      rew_q <= 1'b0;
      lock_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      mot_q <= tru_pkg::TRU_MOT_IDLE;
    end else begin
      fwd_q <= fwd_d;
      bwd_q <= bwd_d;
      rew_q <= rew_d;
      lock_q <= lock_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      mot_q <= mot_d;
    end
  end

  // every channel switched by its own contact, all from one coil
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rd_path_q[i] <= 1'b0;
        wr_path_q[i] <= 1'b0;
      end else begin
        rd_path_q[i] <= rd_d;
        wr_path_q[i] <= wr_d;
      end
    end
  end

  assign cmd.fwd_drive = fwd_q;
  assign cmd.bwd_drive = bwd_q;
  assign cmd.rewind_relay = rew_q;
  assign cmd.rewind_lockout = lock_q;
  assign cmd.read_path = rd_path_q;
  assign cmd.write_path = wr_path_q;
  assign cmd.motion = mot_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_lock_blocks_ref: assert property (lock_q |=> !$rose(fwd_q) && !$rose(rd_q) && !$rose(wr_q))
    else $error("reference accepted while locked out");
  a_path_together: assert property (rd_path_q == {CHANNELS{rd_q}} && wr_path_q == {CHANNELS{wr_q}})
    else $error("path channels not switched together");
  a_rewind_start: assert property (ref_ok && cmd.rewind_command && !cmd.rewind_done |=> rew_q)
    else $error("rewind relay not energized");

endmodule : tru_cmd_decode

// [core/tru_relay_ctrl.sv]
`timescale 1ns/100ps
`include "tru_map.svh"

// Behaviour
// - power-on latch sets on the button, clears once main interlock sets
// - power-on latch enables interlock evaluation and vacuum relay drive
// - main interlock sets with power-on, vacuum and thermal closed, limits open
// - main interlock holds itself, clears power-on, energizes reel relay
// - reel relay follows main interlock, powering reel and center drive
// - vacuum relay on while power-on or main interlock is set
// - selected unit with rewind command energizes the rewind relay
// - select with rewind interlock request sets lockout, blocking references
// - select with forward command drives forward
// - select with backward command drives backward
// - select with read command closes all read path relays
// - select with write command closes all write path relays
// - during read or write, direction report high forward, low backward
// - bad spot under the head, per direction detector, inhibits read and write
// - over-temperature opens the main interlock and drops drive power
// - eight channels, seven data and sprocket, switched together
module tru_relay_ctrl #(
  parameter int CHANNELS = `TRU_CHANNELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_button,
  input wire logic loop_vac_left_ok,
  input wire logic loop_vac_right_ok,
  input wire logic thermal_switch_ok,
  input wire logic fwd_limit_hit,
  input wire logic bwd_limit_hit,
  input wire logic over_temp,
  input wire logic unit_select,
  input wire logic rewind_command,
  input wire logic rewind_interlock_request,
  input wire logic forward_command,
  input wire logic backward_command,
  input wire logic read_command,
  input wire logic write_command,
  input wire logic rewind_done,
  input wire logic fwd_bad_spot,
  input wire logic bwd_bad_spot,
  output logic power_on_latch,
  output logic main_interlock_latch,
  output logic reel_power_relay,
  output logic vacuum_power_relay,
  output logic rewind_relay,
  output logic rewind_lockout,
  output logic fwd_drive,
  output logic bwd_drive,
  output logic [CHANNELS-1:0] read_path_relays,
  output logic [CHANNELS-1:0] write_path_relays,
  output logic direction_report,
  output logic rw_inhibit
);

  logic pon_q;
  logic mi_q;
  logic reel_q;
  logic vac_q;
  logic dir_q;
  logic inh_q;
  logic en_q;
  logic trip_q;
  tru_pkg::tru_word_t prdata_q;
  logic pready_q;
  logic pslverr_q;
  tru_pkg::tru_word_t status_w;
  tru_pkg::tru_word_t rd_mux;

  tru_cmd_if #(.CHANNELS(CHANNELS)) cmd ();

  // power interlock chain
  // the chain switches only through power-on; main interlock then holds itself
  wire chain_ok = loop_vac_left_ok & loop_vac_right_ok & thermal_switch_ok
                & ~fwd_limit_hit & ~bwd_limit_hit;
  wire mi_set = pon_q & chain_ok;
  // over-temperature beats both the set path and the hold path
  wire mi_d = (mi_q | mi_set) & ~over_temp & thermal_switch_ok;
  wire pon_d = (pon_q | power_on_button) & ~mi_q;
  wire vac_d = pon_d | mi_d;
  wire reel_d = mi_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pon_q <= 1'b0;
      mi_q <= 1'b0;
      reel_q <= 1'b0;
      vac_q <= 1'b0;
    end else begin
      pon_q <= pon_d;
      mi_q <= mi_d;
      reel_q <= reel_d;
      vac_q <= vac_d;
    end
  end

  // command decode; no drive, path or rewind start without main interlock power
  assign cmd.enable = mi_q & en_q;
  assign cmd.unit_select = unit_select;
  assign cmd.rewind_command = rewind_command;
  assign cmd.rewind_interlock_request = rewind_interlock_request;
  assign cmd.forward_command = forward_command;
  assign cmd.backward_command = backward_command;
  assign cmd.read_command = read_command;
  assign cmd.write_command = write_command;
  assign cmd.rewind_done = rewind_done;

  tru_cmd_decode #(.CHANNELS(CHANNELS)) u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .cmd(cmd.dec)
  );

  // direction and bad-spot inhibit, from the coils already energized
  wire rw_active = cmd.read_path[0] | cmd.write_path[0];
  wire dir_d = rw_active & cmd.fwd_drive;
  // only the detector facing the current motion is heeded
  wire inh_d = (cmd.fwd_drive & fwd_bad_spot) | (cmd.bwd_drive & bwd_bad_spot);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 1'b0;
      inh_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
      inh_q <= inh_d;
    end
  end

  // apb decode; one access cycle, answer registered in the setup cycle
  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pready_q & pwrite;
  wire hit_ctrl = (paddr == `TRU_CTRL_OFS);
  wire hit_stat = (paddr == `TRU_STATUS_OFS);
  wire hit_trip = (paddr == `TRU_TRIP_OFS);
  wire hit_any = hit_ctrl | hit_stat | hit_trip;
  wire wr_ctrl = wr_acc & hit_ctrl;
  wire wr_trip = wr_acc & hit_trip;
  // lockout clear is a pulse, never stored
  assign cmd.lock_clear = wr_ctrl & pwdata[`TRU_CTRL_LOCKCLR_BIT];
  // a trip during the clearing write still lands
  wire trip_d = over_temp | (trip_q & ~(wr_trip & pwdata[`TRU_TRIP_OT_BIT]));
  wire en_d = wr_ctrl ? pwdata[`TRU_CTRL_ENABLE_BIT] : en_q;

  // status word
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`TRU_ST_PON_BIT] = pon_q;
    status_w[`TRU_ST_MAIN_BIT] = mi_q;
    status_w[`TRU_ST_REEL_BIT] = reel_q;
    status_w[`TRU_ST_VAC_BIT] = vac_q;
    status_w[`TRU_ST_REW_BIT] = cmd.rewind_relay;
    status_w[`TRU_ST_LOCK_BIT] = cmd.rewind_lockout;
    status_w[`TRU_ST_FWD_BIT] = cmd.fwd_drive;
    status_w[`TRU_ST_BWD_BIT] = cmd.bwd_drive;
    status_w[`TRU_ST_READ_BIT] = cmd.read_path[0];
    status_w[`TRU_ST_WRITE_BIT] = cmd.write_path[0];
    status_w[`TRU_ST_DIR_BIT] = dir_q;
    status_w[`TRU_ST_INH_BIT] = inh_q;
    status_w[`TRU_ST_MOT_MSB:`TRU_ST_MOT_LSB] = cmd.motion;
  end

  assign rd_mux = hit_ctrl ? {31'h0000_0000, en_q} :
                  hit_stat ? status_w :
                  hit_trip ? {31'h0000_0000, trip_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'(`TRU_CTRL_RESET);
      trip_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      en_q <= en_d;
      trip_q <= trip_d;
      prdata_q <= setup_ph ? rd_mux : prdata_q;
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~hit_any;
    end
  end

  // outputs, each straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign power_on_latch = pon_q;
  assign main_interlock_latch = mi_q;
  assign reel_power_relay = reel_q;
  assign vacuum_power_relay = vac_q;
  assign rewind_relay = cmd.rewind_relay;
  assign rewind_lockout = cmd.rewind_lockout;
  assign fwd_drive = cmd.fwd_drive;
  assign bwd_drive = cmd.bwd_drive;
  assign read_path_relays = cmd.read_path;
  assign write_path_relays = cmd.write_path;
  assign direction_report = dir_q;
  assign rw_inhibit = inh_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_power_press;
    power_on_button && !mi_q;
  endsequence
  sequence s_chain_closes;
    pon_q && chain_ok && !over_temp;
  endsequence

  a_pon_sets: assert property (s_power_press |=> pon_q)
    else $error("power-on latch did not set");
  a_pon_drops: assert property (mi_q |=> !pon_q)
    else $error("power-on latch not cleared by main interlock");
  a_mi_needs_chain: assert property ($rose(mi_q) |-> $past(pon_q) && $past(chain_ok))
    else $error("main interlock set without closed chain");
  a_mi_sets: assert property (s_chain_closes |=> mi_q)
    else $error("main interlock did not set");
  a_mi_holds: assert property (mi_q && !pon_q && !over_temp && thermal_switch_ok |=> mi_q)
    else $error("main interlock lost hold");
  a_reel_follows: assert property (reel_q == mi_q)
    else $error("reel relay differs from main interlock");
  a_vac_either: assert property (##1 vac_q == (pon_q || mi_q))
    else $error("vacuum relay wrong");
  a_overtemp_trip: assert property (over_temp |=> !mi_q && !reel_q ##1 !fwd_drive && !bwd_drive)
    else $error("over-temperature did not drop power");
  a_fwd_decode: assert property (mi_q && en_q && unit_select && !rewind_lockout && forward_command
                                 && !backward_command |=> fwd_drive)
    else $error("forward drive not energized");
  a_bwd_decode: assert property (mi_q && en_q && unit_select && !rewind_lockout && backward_command
                                 && !forward_command |=> bwd_drive)
    else $error("backward drive not energized");
  a_read_decode: assert property (mi_q && en_q && unit_select && !rewind_lockout && read_command
                                  && !write_command |=> read_path_relays == {CHANNELS{1'b1}})
    else $error("read path not closed");
  a_write_decode: assert property (mi_q && en_q && unit_select && !rewind_lockout && write_command
                                   && !read_command |=> write_path_relays == {CHANNELS{1'b1}})
    else $error("write path not closed");
  a_no_select_idle: assert property (!unit_select && !rewind_relay |=> !fwd_drive && !bwd_drive)
    else $error("motion without unit select");
  a_lock_sets: assert property (unit_select && rewind_interlock_request |=> rewind_lockout)
    else $error("lockout did not set");
  a_dir_report: assert property (##1 direction_report == $past(rw_active && fwd_drive))
    else $error("direction report wrong");
  a_bad_spot: assert property (fwd_drive && fwd_bad_spot |=> rw_inhibit)
    else $error("bad spot did not inhibit");
  a_apb_ready: assert property (setup_ph |=> pready && (pslverr == !$past(hit_any)))
    else $error("apb answer wrong");

  // release and hold paths; a latch that never lets go would still pass the set checks above
  sequence s_main_rises;
    $rose(mi_q);
  endsequence

  a_pon_handover: assert property (s_main_rises |-> reel_power_relay ##1 !pon_q)
    else $error("power-on latch kept after main interlock");
  a_pon_needs_button: assert property ($rose(pon_q) |-> $past(power_on_button))
    else $error("power-on latch set without button");
  a_vac_with_pon: assert property ($rose(pon_q) |-> vacuum_power_relay)
    else $error("vacuum relay not driven by power-on latch");
  a_no_power_idle: assert property (!mi_q |=> !fwd_drive && !bwd_drive)
    else $error("drive without main interlock");
  a_trip_sets: assert property (over_temp |=> trip_q)
    else $error("over-temperature trip not recorded");
  a_trip_holds: assert property (trip_q && !wr_trip |=> trip_q)
    else $error("trip flag lost");
  a_trip_clears: assert property (wr_trip && pwdata[`TRU_TRIP_OT_BIT] && !over_temp |=> !trip_q)
    else $error("trip flag not cleared");
  a_rewind_holds: assert property (rewind_relay && !rewind_done |=> rewind_relay)
    else $error("rewind relay dropped early");
  a_rewind_ends: assert property (rewind_done |=> !rewind_relay)
    else $error("rewind relay held after done");
  a_lock_holds: assert property (rewind_lockout && !rewind_done && !cmd.lock_clear |=> rewind_lockout)
    else $error("lockout dropped early");
  a_lock_releases: assert property (cmd.lock_clear && !rewind_interlock_request |=> !rewind_lockout)
    else $error("lockout not cleared by software");
  a_dir_backward: assert property (bwd_drive |=> !direction_report)
    else $error("direction report forward while moving backward");
  a_dir_idle: assert property (!read_path_relays[0] && !write_path_relays[0] |=> !direction_report)
    else $error("direction reported outside read or write");
  a_bwd_bad_spot: assert property (bwd_drive && bwd_bad_spot |=> rw_inhibit)
    else $error("backward bad spot did not inhibit");
  a_inh_facing: assert property (fwd_drive && !bwd_drive && !fwd_bad_spot |=> !rw_inhibit)
    else $error("inhibit from the detector facing away");
  a_path_exclusive: assert property (!(read_path_relays[0] && write_path_relays[0]))
    else $error("read and write paths closed together");
  a_no_select_path: assert property (!unit_select |=> !read_path_relays[0] && !write_path_relays[0])
    else $error("path closed without unit select");

endmodule : tru_relay_ctrl

// [dv/tru_ioc_model.sv]
`timescale 1ns/100ps

// host side: one operation code picks select and command levels
module tru_ioc_model (
  input wire logic [2:0] op,
  output logic unit_select,
  output logic rewind_command,
  output logic rewind_interlock_request,
  output logic forward_command,
  output logic backward_command,
  output logic read_command,
  output logic write_command
);
  // op 7 addresses some other unit, so this select stays low
  assign unit_select = (op != 3'h0) && (op != 3'h7);
  assign rewind_command = (op == 3'h1);
  assign rewind_interlock_request = (op == 3'h2);
  // no op ever pairs the two directions, or read with write
  assign forward_command = (op == 3'h3) || (op == 3'h5) || (op == 3'h7);
  assign backward_command = (op == 3'h4) || (op == 3'h6);
  assign read_command = (op == 3'h5);
  assign write_command = (op == 3'h6);
endmodule : tru_ioc_model

// [dv/testbench.sv]
`timescale 1ns/100ps
`include "tru_map.svh"

module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic power_on_button = 1'b0;
  logic [4:0] bad = 5'h01; // a set bit blocks one element of the chain
  logic over_temp = 1'b0;
  logic rewind_done = 1'b0;
  logic fwd_bad_spot = 1'b0;
  logic bwd_bad_spot = 1'b0;
  logic [2:0] op = 3'h0;
  logic sel, rew_c, rir_c, fwd_c, bwd_c, rd_c, wr_c;
  logic pon, main_il, reel, vac, rew, lock, fwd, bwd, dir, inh;
  logic [7:0] rpath, wpath;
  logic [25:0] outs;
  logic [31:0] rdat;
  logic rerr;
  logic [4:0] e;
  logic [2:0] ops [5] = '{3'h5, 3'h6, 3'h3, 3'h4, 3'h7};
  logic [4:0] exps [5] = '{5'h15, 5'h0a, 5'h10, 5'h08, 5'h00};
  int failures = 0;
  int checked = 0;
  int i;

  assign outs = {pon, main_il, reel, vac, rew, lock, fwd, bwd, rpath, wpath, dir, inh};

  // 20 MHz system clock
  initial begin
    forever #25 pclk = ~pclk;
  end

  tru_ioc_model i_ioc (.op(op), .unit_select(sel), .rewind_command(rew_c), .rewind_interlock_request(rir_c),
    .forward_command(fwd_c), .backward_command(bwd_c), .read_command(rd_c), .write_command(wr_c));

  tru_relay_ctrl #(.CHANNELS(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_button(power_on_button), .loop_vac_left_ok(~bad[0]), .loop_vac_right_ok(~bad[1]),
    .thermal_switch_ok(~bad[2]), .fwd_limit_hit(bad[3]), .bwd_limit_hit(bad[4]), .over_temp(over_temp),
    .unit_select(sel), .rewind_command(rew_c), .rewind_interlock_request(rir_c), .forward_command(fwd_c),
    .backward_command(bwd_c), .read_command(rd_c), .write_command(wr_c), .rewind_done(rewind_done),
    .fwd_bad_spot(fwd_bad_spot), .bwd_bad_spot(bwd_bad_spot), .power_on_latch(pon),
    .main_interlock_latch(main_il), .reel_power_relay(reel), .vacuum_power_relay(vac), .rewind_relay(rew),
    .rewind_lockout(lock), .fwd_drive(fwd), .bwd_drive(bwd), .read_path_relays(rpath),
    .write_path_relays(wpath), .direction_report(dir), .rw_inhibit(inh));

  task results;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // let n edges pass, then look once their updates have landed
  task step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : step

  // one apb transfer; the wait for pready is bounded
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      results();
    end
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask : rd_chk

  // hang guard
  initial begin
    repeat (4000) @(posedge pclk);
    failures++;
    results();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    step(1);
    chk(32'(outs), 32'h0000_0000);
    rd_chk(`TRU_CTRL_OFS, 32'h0000_0000);
    rd_chk(`TRU_STATUS_OFS, 32'h0000_0000);
    rd_chk(8'h0c, 32'h0000_0000);
    chk(32'(rerr), 32'h0000_0001);
    $display("test reset done");
    // power up with the chain blocked by each element in turn
    @(posedge pclk);
    power_on_button <= 1'b1;
    @(posedge pclk);
    power_on_button <= 1'b0;
    #1;
    chk(32'({pon, vac, main_il}), 32'h0000_0006);
    for (i = 0; i < 5; i++) begin
      @(posedge pclk);
      bad <= 5'(1 << i);
      step(1);
      chk(32'({pon, main_il, reel}), 32'h0000_0004);
    end
    @(posedge pclk);
    bad <= 5'h00;
    step(1);
    chk(32'({pon, main_il, reel, vac}), 32'h0000_000f);
    step(1);
    chk(32'({pon, main_il, reel, vac}), 32'h0000_0007);
    $display("test power done");
    // commands are ignored until the enable bit is written
    @(posedge pclk);
    op <= 3'h3;
    step(2);
    chk(32'(fwd), 32'h0000_0000);
    apb(1'b1, `TRU_CTRL_OFS, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      @(posedge pclk);
      op <= ops[i];
      step(2);
      e = exps[i];
      chk(32'({fwd, bwd, rpath, wpath, dir}), 32'({e[4], e[3], {8{e[2]}}, {8{e[1]}}, e[0]}));
    end
    @(posedge pclk);
    op <= 3'h5;
    step(2);
    rd_chk(`TRU_STATUS_OFS, 32'h0000_154e);
    $display("test commands done");
    // backward write: only the backward detector may inhibit
    @(posedge pclk);
    op <= 3'h6;
    fwd_bad_spot <= 1'b1;
    step(3);
    chk(32'(inh), 32'h0000_0000);
    @(posedge pclk);
    fwd_bad_spot <= 1'b0;
    bwd_bad_spot <= 1'b1;
    for (i = 0; i < 4 && inh !== 1'b1; i++) step(1);
    chk(32'(inh), 32'h0000_0001);
    @(posedge pclk);
    bwd_bad_spot <= 1'b0;
    for (i = 0; i < 4 && inh !== 1'b0; i++) step(1);
    chk(32'(inh), 32'h0000_0000);
    $display("test bad spot done");
    // rewind holds after the command is gone, until done
    @(posedge pclk);
    op <= 3'h1;
    @(posedge pclk);
    op <= 3'h0;
    step(1);
    chk(32'(rew), 32'h0000_0001);
    rd_chk(`TRU_STATUS_OFS, 32'h0000_301e);
    @(posedge pclk);
    rewind_done <= 1'b1;
    @(posedge pclk);
    rewind_done <= 1'b0;
    step(1);
    chk(32'(rew), 32'h0000_0000);
    // lockout blocks a following forward until software clears it
    @(posedge pclk);
    op <= 3'h2;
    @(posedge pclk);
    op <= 3'h3;
    step(2);
    chk(32'({lock, fwd}), 32'h0000_0002);
    apb(1'b1, `TRU_CTRL_OFS, 32'h0000_0003);
    step(2);
    chk(32'({lock, fwd}), 32'h0000_0001);
    rd_chk(`TRU_CTRL_OFS, 32'h0000_0001);
    $display("test rewind done");
    // over-temperature pulse drops interlock, reel, then drive
    @(posedge pclk);
    over_temp <= 1'b1;
    @(posedge pclk);
    over_temp <= 1'b0;
    #1;
    chk(32'({main_il, reel}), 32'h0000_0000);
    step(1);
    chk(32'({fwd, vac}), 32'h0000_0000);
    rd_chk(`TRU_TRIP_OFS, 32'h0000_0001);
    apb(1'b1, `TRU_TRIP_OFS, 32'h0000_0001);
    rd_chk(`TRU_TRIP_OFS, 32'h0000_0000);
    $display("test thermal done");
    // second reset in mid-run, with the latches energized and enable still set
    @(posedge pclk);
    power_on_button <= 1'b1;
    @(posedge pclk);
    power_on_button <= 1'b0;
    step(1);
    chk(32'({pon, main_il}), 32'h0000_0003);
    @(posedge pclk);
    presetn <= 1'b0;
    step(1);
    chk(32'(outs), 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`TRU_CTRL_OFS, 32'h0000_0000);
    $display("test rereset done");
    results();
  end
endmodule : testbench
